// ---- rtl/ebas_regs.vh ----
// Constants for the external bus access sequencer.
`ifndef EBAS_REGS_VH
`define EBAS_REGS_VH
`define EBAS_WIDTH_8 2'h0
`define EBAS_WIDTH_16 2'h1
`define EBAS_WIDTH_32 2'h2
`define EBAS_SIZE_BYTE 3'h0
`define EBAS_SIZE_SHORT 3'h1
`define EBAS_SIZE_WORD 3'h2
`define EBAS_SIZE_DOUBLE 3'h3
`define EBAS_SIZE_TRIPLE 3'h4
`define EBAS_SIZE_QUAD 3'h5
`define EBAS_BURST_MAX 3'h4
`define EBAS_AD_WAIT_MAX 5'h1F
`define EBAS_DD_WAIT_MAX 2'h3
`define EBAS_XDA_WAIT_MAX 2'h3
`endif

// ---- rtl/ebas_lane_encode.v ----
// Byte enable encoding and data lane replication for one transfer.
`timescale 1ns/100ps
module ebas_lane_encode (
  // Transfer description
  input wire [1:0] bus_width,
  input wire [1:0] low_addr,
  input wire [2:0] size,
  input wire [31:0] wdata_in,
  // Encoded outputs
  output reg [3:0] lane_enable_n,
  output reg [31:0] wdata_out
);
`include "ebas_regs.vh"
  always @* begin
    lane_enable_n = 4'hF;
    wdata_out = wdata_in;
    case (bus_width)
      `EBAS_WIDTH_8: begin
        // Upper two enables are don't-care and held high.
        lane_enable_n = {2'h3, low_addr[1], low_addr[0]};
        wdata_out = {4{wdata_in[7:0]}};
      end
      `EBAS_WIDTH_16: begin
        if (size == `EBAS_SIZE_BYTE) begin
          lane_enable_n = {~low_addr[0], 1'h1, low_addr[1],
            low_addr[0]};
        end else begin
          lane_enable_n = {1'h0, 1'h1, low_addr[1], 1'h0};
        end
        wdata_out = {2{wdata_in[15:0]}};
      end
      default: begin
        if (size == `EBAS_SIZE_BYTE) begin
          lane_enable_n = ~(4'h1 << low_addr);
        end else if (size == `EBAS_SIZE_SHORT) begin
          lane_enable_n = low_addr[1] ? 4'h3 : 4'hC;
        end else begin
          lane_enable_n = 4'h0;
        end
      end
    endcase
  end
endmodule // ebas_lane_encode

// ---- rtl/ebas_wait_counter.v ----
// Loadable down counter for internal wait states.
`timescale 1ns/100ps
module ebas_wait_counter (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Control
  input wire load,
  input wire [4:0] load_value,
  // Status
  output wire busy
);
  reg [4:0] count_reg;
  reg [4:0] count_next;
  always @* begin
    count_next = count_reg;
    if (load) begin
      count_next = load_value;
    end else if (count_reg != 5'h00) begin
      count_next = count_reg - 5'h01;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      count_reg <= 5'h00;
    end else begin
      count_reg <= count_next;
    end
  end
  assign busy = (count_reg != 5'h00);
endmodule // ebas_wait_counter

// ---- rtl/ebas_sequencer.v ----
// External bus access sequencer: address, data, wait and burst phases.
//
// Behaviour
// - Non-burst transfer is one address cycle, then one data cycle plus waits.
// - Address-to-data waits come from read or write region count.
// - Data-to-data waits are ignored in regions without burst.
// - Address cycle edge asserts strobe and drives address and status.
// - Direction changes on falling edge, never while enable is asserted.
// - Transceiver enable asserts on the edge ending the address cycle.
// - Counter strobe held asserted while the wait counter counts address or data-to-data waits, not turnaround.
// - With ready control, waits continue after the count until ready low.
// - With ready control, burst cut ignores ready, accepts data, new address cycle for rest.
// - Last-transfer asserts in final data cycle; enable deasserts there.
// - Turnaround waits follow the last data cycle before a new address.
// - Burst is one address cycle and two to four data cycles.
// - Wide requests on narrow buses split into bursts of up to four.
// - Burst uses 0-31 address-to-data and 0-3 data-to-data waits.
// - Two lowest address bits increment after each burst data cycle.
// - 32-bit bursts start aligned to quad or double word as sized.
// - 16-bit bursts aligned; data duplicated onto upper sixteen lines.
// - 8-bit bursts aligned; byte repeated on upper three byte lanes.
// - Word read on 32-bit region asserts all four lane enables.
// - Enable and direction stay asserted throughout the burst.
// - Each non-final burst data cycle is followed by data-to-data waits.
// - 8-bit region: enables 0 and 1 carry address bits 0 and 1.
// - 16-bit region: enable 1 is A1, enable 2 high, enable 0 low byte.
// - 32-bit region: each enable directly selects its own byte lane.
// - Ready ignored in idle, address and turnaround cycles.
`timescale 1ns/100ps
module ebas_sequencer (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Request port from the processor core
  input wire req_valid,
  input wire req_write,
  input wire [31:0] req_addr,
  input wire [2:0] req_size,
  input wire [31:0] req_wdata,
  input wire req_supervisor,
  input wire req_code,
  input wire req_dma,
  output reg req_ready,
  output reg rdata_valid,
  output reg [31:0] rdata,
  output reg done,
  // Region configuration
  input wire [1:0] cfg_bus_width,
  input wire cfg_burst_en,
  input wire cfg_ready_en,
  input wire [4:0] read_addr_to_data_waits,
  input wire [4:0] write_addr_to_data_waits,
  input wire [1:0] read_data_to_data_waits,
  input wire [1:0] write_data_to_data_waits,
  input wire [1:0] turnaround_waits,
  // External bus
  input wire ready_n,
  input wire burst_cut_n,
  input wire [31:0] data_in,
  output reg [31:2] address,
  output reg [3:0] lane_enable_n,
  output reg [31:0] data_out,
  output reg [31:0] data_out_en,
  output reg address_strobe_n,
  output reg supervisor_access_n,
  output reg data_code,
  output reg dma_access_n,
  output reg write_read,
  output reg transceiver_direction,
  output reg transceiver_enable_n,
  output reg counter_strobe_n,
  output reg last_transfer_n
);
`include "ebas_regs.vh"
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_ADDR = 5'h02;
  localparam [4:0] S_WAIT = 5'h04;
  localparam [4:0] S_DATA = 5'h08;
  localparam [4:0] S_TURN = 5'h10;

  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [31:0] addr_reg;
  reg [2:0] size_reg;
  reg write_reg;
  reg [31:0] wdata_reg;
  reg [4:0] total_reg;
  reg [2:0] burst_left_reg;
  reg [1:0] width_reg;
  reg burst_reg;
  reg ready_en_reg;
  reg [1:0] dd_reg;
  reg [4:0] ad_reg;
  reg resume_reg;
  reg [1:0] enc_width;
  reg [2:0] enc_size;
  reg [1:0] enc_low;
  reg wait_load;
  reg [4:0] wait_value;
  wire wait_busy;
  wire [3:0] enc_lanes;
  wire [31:0] enc_wdata;
  reg [4:0] xfer_total;
  reg [2:0] burst_len;
  reg [1:0] step_addr;
  reg [31:0] addr_inc;
  reg data_taken;
  reg final_xfer;
  reg burst_final;

  ebas_wait_counter u_wait (
    .clk(clk),
    .rst(rst),
    .load(wait_load),
    .load_value(wait_value),
    .busy(wait_busy)
  );

  ebas_lane_encode u_lane (
    .bus_width(enc_width),
    .low_addr(enc_low),
    .size(enc_size),
    .wdata_in(wdata_reg),
    .lane_enable_n(enc_lanes),
    .wdata_out(enc_wdata)
  );

  // Transfer count per request and bus width; a quad on 8 bits is 16.
  always @* begin
    case (req_size)
      `EBAS_SIZE_BYTE: xfer_total = 5'h01;
      `EBAS_SIZE_SHORT: xfer_total = 5'h02;
      `EBAS_SIZE_WORD: xfer_total = 5'h04;
      `EBAS_SIZE_DOUBLE: xfer_total = 5'h08;
      `EBAS_SIZE_TRIPLE: xfer_total = 5'h0C;
      default: xfer_total = 5'h10;
    endcase
    if (cfg_bus_width == `EBAS_WIDTH_16) begin
      xfer_total = (xfer_total == 5'h01) ? 5'h01 : {1'h0, xfer_total[4:1]};
    end else if (cfg_bus_width == `EBAS_WIDTH_32) begin
      xfer_total = (xfer_total[4:2] == 3'h0) ? 5'h01 :
        {2'h0, xfer_total[4:2]};
    end
  end

  // Burst stepping bits; the encoder sees the offered request while idle
  // and the next transfer's address in data cycles.
  always @* begin
    enc_width = (state_reg == S_IDLE) ? cfg_bus_width : width_reg;
    enc_size = (state_reg == S_IDLE) ? req_size : size_reg;
    enc_low = (state_reg == S_IDLE) ? req_addr[1:0] :
      (state_reg == S_DATA) ? addr_inc[1:0] : addr_reg[1:0];
    case (width_reg)
      `EBAS_WIDTH_8: step_addr = addr_reg[1:0];
      `EBAS_WIDTH_16: step_addr = addr_reg[2:1];
      default: step_addr = addr_reg[3:2];
    endcase
  end

  // Advance one bus width; only the two lowest stepping bits roll within
  // a burst, the carry lands in the next burst's base address.
  always @* begin
    case (width_reg)
      `EBAS_WIDTH_8: addr_inc = addr_reg + 32'h00000001;
      `EBAS_WIDTH_16: addr_inc = addr_reg + 32'h00000002;
      default: addr_inc = addr_reg + 32'h00000004;
    endcase
  end

  // Burst length from remaining count and alignment; a start not aligned
  // to the length gets a shorter burst, so bursts stay legal.
  always @* begin
    if (!burst_reg) begin
      burst_len = 3'h1;
    end else if (total_reg >= 5'h04 && step_addr == 2'h0) begin
      burst_len = `EBAS_BURST_MAX;
    end else if (total_reg == 5'h03 && step_addr == 2'h0) begin
      burst_len = 3'h3;
    end else if (total_reg >= 5'h02 && step_addr[0] == 1'h0) begin
      burst_len = 3'h2;
    end else begin
      burst_len = 3'h1;
    end
  end

  // Ready and burst cut are only sampled in data cycles.
  always @* begin
    data_taken = 1'h0;
    if (state_reg == S_DATA) begin
      if (!ready_en_reg) begin
        data_taken = 1'h1;
      end else if (!burst_cut_n) begin
        data_taken = 1'h1;
      end else begin
        data_taken = !ready_n;
      end
    end
  end

  always @* begin
    burst_final = (burst_left_reg == 3'h1) ||
      (ready_en_reg && !burst_cut_n);
    final_xfer = (total_reg == 5'h01);
  end

  // Next state and wait counter loading.
  always @* begin
    state_next = state_reg;
    wait_load = 1'h0;
    wait_value = 5'h00;
    case (state_reg)
      S_IDLE: begin
        if (req_valid) begin
          state_next = S_ADDR;
        end
      end
      S_ADDR: begin
        wait_load = (ad_reg != 5'h00);
        wait_value = ad_reg - 5'h01;
        state_next = (ad_reg == 5'h00) ? S_DATA : S_WAIT;
      end
      S_WAIT: begin
        state_next = wait_busy ? S_WAIT : S_DATA;
      end
      S_DATA: begin
        if (data_taken) begin
          if (final_xfer) begin
            wait_load = (turnaround_waits != 2'h0);
            wait_value = {3'h0, turnaround_waits} - 5'h01;
            state_next = (turnaround_waits == 2'h0) ? S_IDLE : S_TURN;
          end else if (burst_final) begin
            state_next = S_ADDR;
          end else begin
            wait_load = (dd_reg != 2'h0);
            wait_value = {3'h0, dd_reg} - 5'h01;
            state_next = (dd_reg == 2'h0) ? S_DATA : S_WAIT;
          end
        end
      end
      S_TURN: begin
        // Ready is not looked at here, so turnaround cannot stretch.
        if (!wait_busy) begin
          state_next = S_IDLE;
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
      addr_reg <= 32'h00000000;
      size_reg <= 3'h0;
      write_reg <= 1'h0;
      wdata_reg <= 32'h00000000;
      total_reg <= 5'h00;
      burst_left_reg <= 3'h0;
      width_reg <= 2'h0;
      burst_reg <= 1'h0;
      ready_en_reg <= 1'h0;
      dd_reg <= 2'h0;
      ad_reg <= 5'h00;
      resume_reg <= 1'h0;
      req_ready <= 1'h0;
      rdata_valid <= 1'h0;
      rdata <= 32'h00000000;
      done <= 1'h0;
      address <= 30'h00000000;
      lane_enable_n <= 4'hF;
      data_out <= 32'h00000000;
      data_out_en <= 32'h00000000;
      address_strobe_n <= 1'h1;
      supervisor_access_n <= 1'h1;
      data_code <= 1'h0;
      dma_access_n <= 1'h1;
      write_read <= 1'h0;
      transceiver_enable_n <= 1'h1;
      counter_strobe_n <= 1'h1;
      last_transfer_n <= 1'h1;
    end else begin
      state_reg <= state_next;
      req_ready <= (state_next == S_IDLE);
      rdata_valid <= 1'h0;
      done <= 1'h0;
      address_strobe_n <= 1'h1;
      counter_strobe_n <= 1'h1;
      last_transfer_n <= 1'h1;
      if (state_reg == S_IDLE && req_valid) begin
        addr_reg <= req_addr;
        size_reg <= req_size;
        write_reg <= req_write;
        wdata_reg <= req_wdata;
        total_reg <= xfer_total;
        width_reg <= cfg_bus_width;
        burst_reg <= cfg_burst_en;
        ready_en_reg <= cfg_ready_en;
        ad_reg <= req_write ? write_addr_to_data_waits :
          read_addr_to_data_waits;
        dd_reg <= cfg_burst_en ? (req_write ? write_data_to_data_waits :
          read_data_to_data_waits) : 2'h0;
        req_ready <= 1'h0;
      end
      if (state_next == S_ADDR) begin
        address_strobe_n <= 1'h0;
        address <= (state_reg == S_IDLE) ? req_addr[31:2] :
          addr_inc[31:2];
        lane_enable_n <= enc_lanes;
        supervisor_access_n <= (state_reg == S_IDLE) ? !req_supervisor :
          supervisor_access_n;
        data_code <= (state_reg == S_IDLE) ? req_code : data_code;
        dma_access_n <= (state_reg == S_IDLE) ? !req_dma : dma_access_n;
        write_read <= (state_reg == S_IDLE) ? req_write : write_read;
      end
      if (state_reg == S_ADDR) begin
        burst_left_reg <= resume_reg ? burst_left_reg : burst_len;
        resume_reg <= 1'h0;
        transceiver_enable_n <= 1'h0;
        data_out <= enc_wdata;
        data_out_en <= write_reg ? 32'hFFFFFFFF : 32'h00000000;
      end
      if (state_next == S_WAIT) begin
        counter_strobe_n <= 1'h0;
      end
      if (state_next == S_DATA && ((state_reg == S_ADDR) ?
          ((resume_reg ? burst_left_reg : burst_len) == 3'h1) :
          (burst_left_reg == 3'h1 ||
          (data_taken && burst_left_reg == 3'h2)))) begin
        last_transfer_n <= 1'h0;
      end
      if (data_taken) begin
        rdata <= data_in;
        rdata_valid <= !write_reg;
        addr_reg <= addr_inc;
        total_reg <= total_reg - 5'h01;
        burst_left_reg <= burst_left_reg - 3'h1;
        if (!final_xfer && !burst_final) begin
          lane_enable_n <= enc_lanes;
          address <= addr_inc[31:2];
        end
        if (final_xfer) begin
          transceiver_enable_n <= 1'h1;
          data_out_en <= 32'h00000000;
          done <= 1'h1;
        end else if (burst_final) begin
          transceiver_enable_n <= 1'h1;
          resume_reg <= (burst_left_reg != 3'h1);
        end
      end
    end
  end

  // Direction moves on the falling edge after the address strobe, while
  // the transceiver enable is still high, so it never toggles under it.
  always @(negedge clk) begin
    if (rst) begin
      transceiver_direction <= 1'h0;
    end else if (state_reg == S_ADDR) begin
      transceiver_direction <= write_reg;
    end
  end
endmodule // ebas_sequencer

// ---- tb/ebas_seq_chk.sv ----
// Port-level assertion checker for the external bus access sequencer.
`timescale 1ns/100ps
module ebas_seq_chk (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Request and configuration
  input wire req_valid,
  input wire req_ready,
  input wire cfg_burst_en,
  input wire cfg_ready_en,
  input wire [4:0] read_addr_to_data_waits,
  input wire [4:0] write_addr_to_data_waits,
  // External bus
  input wire address_strobe_n,
  input wire write_read,
  input wire transceiver_direction,
  input wire transceiver_enable_n,
  input wire counter_strobe_n,
  input wire last_transfer_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  reg [4:0] ad_left;
  wire [4:0] ad_w;
  assign ad_w = write_read ? write_addr_to_data_waits : read_addr_to_data_waits;
  // Cycles of address-to-data wait still owed after the address cycle.
  always @(posedge clk) begin
    if (rst)
      ad_left <= 5'h00;
    else if (!address_strobe_n)
      ad_left <= ad_w;
    else if (ad_left != 5'h00)
      ad_left <= ad_left - 5'h01;
  end
  property p_take;
    req_valid && req_ready |=> !address_strobe_n;
  endproperty
  property p_strobe_one;
    !address_strobe_n |=> address_strobe_n;
  endproperty
  property p_enable_on_end;
    !address_strobe_n |=> !transceiver_enable_n;
  endproperty
  property p_reset_idle;
    @(posedge clk) disable iff (1'b0) rst |=> address_strobe_n &&
      transceiver_enable_n && counter_strobe_n && last_transfer_n;
  endproperty
  property p_enable_drops;
    $rose(last_transfer_n) |-> transceiver_enable_n;
  endproperty
  property p_dir_stable;
    !transceiver_enable_n && $past(!transceiver_enable_n)
      |-> $stable(transceiver_direction);
  endproperty
  property p_ad_waits;
    ad_left != 5'h00 |-> !counter_strobe_n && address_strobe_n;
  endproperty
  property p_ad_end;
    ad_left == 5'h01 |=> counter_strobe_n;
  endproperty
  property p_nonburst_single;
    !cfg_burst_en && !cfg_ready_en && ad_left == 5'h01 |=> !last_transfer_n;
  endproperty
  a_take: assert property (p_take)
    else $error("no address cycle after take");
  a_strobe_one: assert property (p_strobe_one)
    else $error("address strobe longer than one cycle");
  a_enable_on_end: assert property (p_enable_on_end)
    else $error("enable missing after address cycle");
  a_reset_idle: assert property (p_reset_idle)
    else $error("bus not idle after reset");
  a_enable_drops: assert property (p_enable_drops)
    else $error("enable held past last transfer");
  a_dir_stable: assert property (p_dir_stable)
    else $error("direction moved while enabled");
  a_ad_waits: assert property (p_ad_waits)
    else $error("counter strobe missing in wait");
  a_ad_end: assert property (p_ad_end)
    else $error("address wait count too long");
  a_nonburst_single: assert property (p_nonburst_single)
    else $error("single data cycle missing");
  c_write: cover property (!address_strobe_n && write_read);
  c_max_wait: cover property (ad_left == 5'h1F);
  c_nonburst: cover property ($fell(last_transfer_n) && !cfg_burst_en);
endmodule // ebas_seq_chk

bind ebas_sequencer ebas_seq_chk u_ebas_seq_chk (.clk, .rst, .req_valid,
  .req_ready, .cfg_burst_en, .cfg_ready_en, .read_addr_to_data_waits,
  .write_addr_to_data_waits, .address_strobe_n, .write_read,
  .transceiver_direction, .transceiver_enable_n, .counter_strobe_n,
  .last_transfer_n);

// ---- tb/ebas_mem_model.sv ----
// Memory model that answers the sequencer's external bus.
`timescale 1ns/100ps
module ebas_mem_model (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Behaviour controls
  input wire [1:0] extra,
  input wire cut_en,
  // External bus
  input wire [31:2] address,
  input wire address_strobe_n,
  input wire transceiver_enable_n,
  input wire counter_strobe_n,
  output wire ready_n,
  output wire burst_cut_n,
  output wire [31:0] data_in
);
  reg [1:0] held;
  reg first;
  wire live;
  // Data can move only once the internal count has run out.
  assign live = !transceiver_enable_n && counter_strobe_n && address_strobe_n;
  // With no extra waits ready sits low everywhere, idle cycles included.
  assign ready_n = held < extra;
  assign burst_cut_n = !(cut_en && live && first && !ready_n &&
    address[3:2] == 2'h0);
  // Outside data cycles the lines carry the inverse pattern, not old data.
  assign data_in = {address, 2'h0} ^ (live ? 32'h5A5A5A5A : 32'hA5A5A5A5);
  always @(posedge clk) begin
    if (rst || !live || !ready_n)
      held <= 2'h0;
    else
      held <= held + 2'h1;
    if (rst || !address_strobe_n)
      first <= 1'b1;
    else if (live && !ready_n)
      first <= 1'b0;
  end
endmodule // ebas_mem_model

// ---- tb/ebas_sequencer_tb_top.sv ----
// Self-checking bench for the external bus access sequencer.
`timescale 1ns/100ps
module ebas_sequencer_tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg req_valid = 1'b0, req_write = 1'b0, req_supervisor = 1'b0;
  reg req_code = 1'b0, req_dma = 1'b0, cfg_burst_en = 1'b0;
  reg cfg_ready_en = 1'b0, cut_en = 1'b0;
  reg [31:0] req_addr = 32'h0, req_wdata = 32'h0;
  reg [2:0] req_size = 3'h0;
  reg [1:0] cfg_bus_width = 2'h2, extra = 2'h0, turnaround_waits = 2'h0;
  reg [1:0] read_data_to_data_waits = 2'h0, write_data_to_data_waits = 2'h0;
  reg [4:0] read_addr_to_data_waits = 5'h0, write_addr_to_data_waits = 5'h0;
  wire req_ready, rdata_valid, done, ready_n, burst_cut_n;
  wire address_strobe_n, supervisor_access_n, data_code, dma_access_n;
  wire write_read, transceiver_direction, transceiver_enable_n;
  wire counter_strobe_n, last_transfer_n;
  wire [31:0] rdata, data_in, data_out, data_out_en;
  wire [31:2] address;
  wire [3:0] lane_enable_n;
  integer err_total = 0, checks_done = 0, cyc = 0, gap = 99, ta_prev = 0;
  integer n_as, n_cs, n_den, n_last, n_rv, i, tn = 0;
  reg lq = 1'b1, fs = 1'b0;
  reg [3:0] f_lane;
  reg [31:2] f_addr;
  reg [3:0] f_st;

  ebas_sequencer u_ebas_sequencer (.clk, .rst, .req_valid, .req_write,
    .req_addr, .req_size, .req_wdata, .req_supervisor, .req_code, .req_dma,
    .req_ready, .rdata_valid, .rdata, .done, .cfg_bus_width, .cfg_burst_en,
    .cfg_ready_en, .read_addr_to_data_waits, .write_addr_to_data_waits,
    .read_data_to_data_waits, .write_data_to_data_waits, .turnaround_waits,
    .ready_n, .burst_cut_n, .data_in, .address, .lane_enable_n, .data_out,
    .data_out_en, .address_strobe_n, .supervisor_access_n, .data_code,
    .dma_access_n, .write_read, .transceiver_direction,
    .transceiver_enable_n, .counter_strobe_n, .last_transfer_n);
  ebas_mem_model u_ebas_mem_model (.clk, .rst, .extra, .cut_en, .address,
    .address_strobe_n, .transceiver_enable_n, .counter_strobe_n, .ready_n,
    .burst_cut_n, .data_in);

  always #5 clk = ~clk;

  task close_out;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
      end
    end
  endtask

  function [3:0] lane_exp(input [1:0] w, input [2:0] sz, input [1:0] a);
    begin
      if (w == 2'h0)
        lane_exp = {2'h0, a};
      else if (w == 2'h1)
        lane_exp = sz == 3'h0 ? {!a[0], 1'b0, a[1], a[0]} : {2'h0, a[1], 1'b0};
      else if (sz == 3'h0)
        lane_exp = ~(4'h1 << a);
      else
        lane_exp = sz == 3'h1 ? (a[1] ? 4'h3 : 4'hC) : 4'h0;
    end
  endfunction

  // Bus monitor: counts phases of the current request.
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc > 60000) begin
      err_total = err_total + 1;
      close_out;
    end
    if (!rst) begin
      gap = (last_transfer_n && !lq) ? 1 : gap + 1;
      if (!last_transfer_n && lq)
        n_last = n_last + 1;
      lq = last_transfer_n;
      if (!counter_strobe_n)
        n_cs = n_cs + 1;
      if (!transceiver_enable_n)
        n_den = n_den + 1;
      if (!address_strobe_n) begin
        n_as = n_as + 1;
        if (fs) begin
          fs = 1'b0;
          f_lane = lane_enable_n;
          f_addr = address;
          f_st = {supervisor_access_n, dma_access_n, write_read, data_code};
          check(32'(gap > ta_prev), 32'h1);
        end
      end
      if (rdata_valid === 1'b1) begin
        if (cfg_bus_width == 2'h2)
          check(rdata, {req_addr[31:2] + 30'(n_rv), 2'h0} ^ 32'h5A5A5A5A);
        n_rv = n_rv + 1;
      end
      if (!transceiver_enable_n && counter_strobe_n && address_strobe_n &&
          write_read) begin
        check(data_out, cfg_bus_width == 2'h0 ? {4{req_wdata[7:0]}} :
          cfg_bus_width == 2'h1 ? {2{req_wdata[15:0]}} : req_wdata);
        check(data_out_en, 32'hFFFFFFFF);
        check(32'(transceiver_direction), 32'h1);
      end
    end
  end

  task setup(input [1:0] w, input b, input r, input [1:0] ex, input [4:0] ad);
    begin
      @(posedge clk);
      cfg_bus_width <= w;
      cfg_burst_en <= b;
      cfg_ready_en <= r;
      extra <= ex;
      read_addr_to_data_waits <= ad;
      write_addr_to_data_waits <= ad ^ 5'h01;
      {read_data_to_data_waits, write_data_to_data_waits,
        turnaround_waits} <= 6'($urandom);
    end
  endtask

  task run(input [2:0] sz, input wr, input cut);
    integer t, ac, ad, dd, k;
    begin
      #1;
      n_as = 0;
      n_cs = 0;
      n_den = 0;
      n_last = 0;
      n_rv = 0;
      fs = 1'b1;
      k = 0;
      @(posedge clk);
      req_valid <= 1'b1;
      req_write <= wr;
      req_size <= sz;
      req_addr <= $urandom & (32'hFFFFFFFF << (sz > 3'h3 ? 3'h4 : sz));
      req_wdata <= $urandom;
      {req_supervisor, req_code, req_dma} <= 3'($urandom);
      cut_en <= cut;
      @(posedge clk);
      while (req_ready !== 1'b1 && k < 900) begin
        @(posedge clk);
        k = k + 1;
      end
      req_valid <= 1'b0;
      do begin
        @(posedge clk);
        k = k + 1;
      end while (done !== 1'b1 && k < 900);
      @(posedge clk);
      #1;
      check(32'(k < 900), 32'h1);
      t = (sz == 3'h0 ? 1 : sz == 3'h1 ? 2 : sz == 3'h2 ? 4 : 4 * (sz - 1))
        >> cfg_bus_width;
      if (t == 0)
        t = 1;
      ac = cfg_burst_en ? (t + 3) / 4 : t;
      ad = wr ? write_addr_to_data_waits : read_addr_to_data_waits;
      dd = !cfg_burst_en ? 0 : wr ? write_data_to_data_waits :
        read_data_to_data_waits;
      check(n_as, ac + cut);
      check(n_cs, (ac + cut) * ad + (t - ac - cut) * dd);
      if (!wr)
        check(n_rv, t);
      if (!cut) begin
        check(n_last, ac);
        check(n_den, ac * ad + (t - ac) * dd +
          t * (1 + (cfg_ready_en ? extra : 0)));
      end
      check(32'(f_lane & (cfg_bus_width == 2'h0 ? 4'h3 : cfg_bus_width ==
        2'h1 ? 4'hB : 4'hF)), 32'(lane_exp(cfg_bus_width, sz,
        req_addr[1:0])));
      check(32'(f_addr), 32'(req_addr[31:2]));
      check(32'(f_st), 32'({!req_supervisor, !req_dma, wr, req_code}));
      ta_prev = turnaround_waits;
      $display("test %0d done", tn);
      tn = tn + 1;
    end
  endtask

  initial begin
    i = $urandom(32'h17d1c355);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    setup(2'h2, 1'b1, 1'b1, 2'h0, 5'h1F);
    run(3'h5, 1'b0, 1'b1);
    setup(2'h0, 1'b0, 1'b0, 2'h3, 5'h02);
    run(3'h5, 1'b1, 1'b0);
    setup(2'h1, 1'b1, 1'b1, 2'h2, 5'h00);
    run(3'h4, 1'b0, 1'b0);
    for (i = 0; i < 40; i = i + 1) begin
      setup(2'($urandom % 3), 1'($urandom), 1'($urandom), 2'($urandom),
        5'($urandom % 8));
      run(3'($urandom % 6), 1'($urandom), 1'b0);
    end
    close_out;
  end
endmodule // ebas_sequencer_tb_top
